// File: recorder_map.svh
// Register map, field positions and timing constants of the recorder
`ifndef RECORDER_MAP_SVH
`define RECORDER_MAP_SVH

`define MCLK_HZ      125000000
`define TB_OSC_HZ    1000000
`define TB_DECADE    10
`define TB_MAX_DEC   5

`define MEM_DEPTH    64
`define MEM_AW       6
`define SAMPLE_W     16
`define TRIG_W       4

`define ADDR_CTRL    32'h0000_0000
`define ADDR_CONFIG  32'h0000_0004
`define ADDR_DELAY   32'h0000_0008
`define ADDR_LEADOUT 32'h0000_000c
`define ADDR_CIRCLEN 32'h0000_0010
`define ADDR_STATUS  32'h0000_0014

`define CTRL_RUN     0
`define CTRL_STOP    1
`define CTRL_PAUSE   2
`define CTRL_TRIG    3

`define CFG_WMASK    32'h00ff_073f
`define CFG_SEG      5:4
`define CFG_SEG_MAX  2'h2

`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// File: recorder_pkg.sv
// Types shared by the recorder modules
`include "recorder_map.svh"
package recorder_pkg;

  typedef enum logic [3:0]
  {
    st_idle    = 4'b0001,
    st_standby = 4'b0010,
    st_record  = 4'b0100,
    st_hold    = 4'b1000
  } rec_state_t;

  typedef enum logic [1:0]
  {
    sm_sweep = 2'b00,
    sm_cont  = 2'b01,
    sm_dual  = 2'b10
  } store_mode_t;

  typedef enum logic [1:0]
  {
    cm_std      = 2'b00,
    cm_circ     = 2'b01,
    cm_stoptrig = 2'b10
  } cont_mode_t;

  // Layout equals the configuration register word
  typedef struct packed {
    logic [7:0]  pad3;
    logic [7:0]  decim;
    logic [4:0]  pad2;
    logic [2:0]  rate;
    logic [1:0]  pad1;
    logic [1:0]  seg_log;
    cont_mode_t  cmode;
    store_mode_t mode;
  } cfg_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic                  valid;
    logic [1:0]            seg;
    logic [`SAMPLE_W-1:0]  data;
  } xfer_t;

  typedef struct packed {
    logic                  valid;
    logic [15:0]           index;
    logic [`SAMPLE_W-1:0]  data;
  } cont_t;

endpackage

// File: bit_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_regs_t;

  sync_regs_t r;
  sync_regs_t next_r;

  always_comb
  begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// File: sample_timebase.sv
// Base-10 sample clock: 1 MHz reference divided by a power of ten
`timescale 1ns/1ps
`default_nettype none
module sample_timebase (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [2:0] rate_sel,
  output logic            tick
);
  localparam logic [6:0] PRE_LAST = 7'(`MCLK_HZ / `TB_OSC_HZ - 1);

  typedef struct packed {
    logic [6:0]  pre;
    logic [16:0] dec;
    logic        tick;
  } tb_regs_t;

  tb_regs_t    r;
  tb_regs_t    next_r;
  logic [16:0] lim;

  always_comb
  begin
    next_r      = r;
    next_r.tick = 1'b0;
    lim         = 17'h1;
    for (int k = 0; k < `TB_MAX_DEC; k++)
      if (k < int'(rate_sel))
        lim = 17'(lim * `TB_DECADE);
    if (r.pre == PRE_LAST)
    begin
      next_r.pre = '0;
      // Every sample is an equal number of reference periods apart
      if (r.dec >= lim - 17'h1)
      begin
        next_r.dec  = '0;
        next_r.tick = 1'b1;
      end
      else
        next_r.dec = r.dec + 17'h1;
    end
    else
      next_r.pre = r.pre + 7'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick = r.tick;
endmodule
`default_nettype wire

// File: sweep_ring_buffer_recorder.sv
// Segmented ring buffer recorder with sweep and continuous storage
//
// Summary of operation
// - Run records until operator or trigger stop
// - Stop ends or aborts the recording
// - Pause when idle: digitize, store nothing
// - Pause while recording holds; run resumes, stop ends
// - One rate, length, delay for all channels
// - Each sample goes to next buffer location
// - Buffer splits into segments, one sweep each
// - Segment end wraps to its first location
// - Writing stops only at end of sweep
// - Ended sweeps stream out without operator action
// - Zero delay halts storage at trigger
// - Trigger loads delay counter; halt when expired
// - Pre-trigger samples equal length minus delay
// - Delay beyond length keeps only post-trigger samples
// - Dual mode stores sweeps plus decimated stream
// - Standard continuous ends only by commands
// - Circular continuous wraps index, lead-out ends it
// - Stop-on-trigger continuous ends at trigger
// - Samples taken on equidistant time base ticks
// - Rates are base-10 divisions of 1 MHz
// - Recorder trigger is OR of channel triggers
`timescale 1ns/1ps
`default_nettype none
module sweep_ring_buffer_recorder (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire recorder_pkg::axil_req_t axi_req,
  output var  recorder_pkg::axil_rsp_t axi_rsp,
  input  wire logic [`SAMPLE_W-1:0]   adc_data,
  input  wire logic [`TRIG_W-1:0]     chan_trig,
  input  wire logic                   xfer_ready,
  output var  recorder_pkg::xfer_t    xfer,
  output var  recorder_pkg::cont_t    cont
);
  import recorder_pkg::*;

  typedef struct packed {
    rec_state_t                    st;
    cfg_t                          cfg;
    logic [15:0]                   delay;
    logic [15:0]                   leadout;
    logic [15:0]                   circlen;
    logic [1:0]                    seg;
    logic [`MEM_AW-1:0]            off;
    logic                          wrapped;
    logic                          dly_run;
    logic [15:0]                   dly_cnt;
    logic                          lo_run;
    logic [15:0]                   lo_cnt;
    logic [7:0]                    dec_cnt;
    logic [15:0]                   cont_pos;
    logic                          trig_pend;
    logic                          trig_prev;
    logic [`SAMPLE_W-1:0]          last_sample;
    logic [`MEM_DEPTH-1:0][`SAMPLE_W-1:0] mem;
    logic [3:0]                    pend;
    logic [3:0][`MEM_AW-1:0]       m_start;
    logic [3:0][`MEM_AW:0]         m_count;
    logic                          x_busy;
    logic [1:0]                    x_seg;
    logic [`MEM_AW-1:0]            x_off;
    logic [`MEM_AW:0]              x_left;
    xfer_t                         xfer;
    cont_t                         cont;
    logic                          aw_got;
    logic                          w_got;
    logic [31:0]                   awaddr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    axil_rsp_t                     rsp;
  } rec_regs_t;

  rec_regs_t              r;
  rec_regs_t              next_r;
  logic [`SAMPLE_W-1:0]   adc_s;
  logic [`TRIG_W-1:0]     trig_s;
  logic                   tick;
  logic [`MEM_AW:0]       len;
  logic [2:0]             nseg;
  logic [`MEM_AW-1:0]     base;
  logic [`MEM_AW-1:0]     xbase;
  logic [1:0]             sel;
  logic                   run_c;
  logic                   stop_c;
  logic                   pause_c;
  logic                   start_c;
  logic                   trig_c;
  logic                   end_sw;
  logic                   emit;
  logic                   sweep_on;
  logic                   cont_on;
  logic                   cfg_lock;
  logic                   trig_any;
  logic [31:0]            merged;
  cfg_t                   new_cfg;

  function automatic logic [31:0] strb_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    return res;
  endfunction

  bit_sync #(.W(`SAMPLE_W)) u_adc_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    (adc_data),
    .q    (adc_s)
  );

  bit_sync #(.W(`TRIG_W)) u_trig_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    (chan_trig),
    .q    (trig_s)
  );

  sample_timebase u_timebase (
    .mclk     (mclk),
    .rstn     (rstn),
    .rate_sel (r.cfg.rate),
    .tick     (tick)
  );

  always_comb
  begin
    next_r            = r;
    next_r.cont.valid = 1'b0;
    run_c    = 1'b0;
    stop_c   = 1'b0;
    pause_c  = 1'b0;
    start_c  = 1'b0;
    trig_c   = 1'b0;
    end_sw   = 1'b0;
    emit     = 1'b0;
    merged   = '0;
    new_cfg  = r.cfg;
    sel      = '0;
    len      = 7'(`MEM_DEPTH) >> r.cfg.seg_log;
    nseg     = 3'h1 << r.cfg.seg_log;
    base     = 6'(7'(r.seg) * len);
    xbase    = 6'(7'(r.x_seg) * len);
    sweep_on = (r.cfg.mode == sm_sweep) || (r.cfg.mode == sm_dual);
    cont_on  = (r.cfg.mode == sm_cont) || (r.cfg.mode == sm_dual);
    trig_any = |trig_s;
    // Settings stay fixed while any sweep data is in flight
    cfg_lock = (r.st != st_idle) || r.x_busy || (|r.pend);

    // Write channel: address and data may arrive in either order
    if (r.rsp.bvalid && axi_req.bready)
      next_r.rsp.bvalid = 1'b0;
    if (r.rsp.awready && axi_req.awvalid)
    begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = axi_req.awaddr;
    end
    if (r.rsp.wready && axi_req.wvalid)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = axi_req.wdata;
      next_r.wstrb = axi_req.wstrb;
    end
    if (next_r.aw_got && next_r.w_got && !next_r.rsp.bvalid)
    begin
      next_r.aw_got     = 1'b0;
      next_r.w_got      = 1'b0;
      next_r.rsp.bvalid = 1'b1;
      next_r.rsp.bresp  = `RESP_OKAY;
      if (next_r.awaddr == `ADDR_CTRL)
      begin
        if (next_r.wstrb[0])
        begin
          run_c   = next_r.wdata[`CTRL_RUN];
          stop_c  = next_r.wdata[`CTRL_STOP];
          pause_c = next_r.wdata[`CTRL_PAUSE];
          trig_c  = next_r.wdata[`CTRL_TRIG];
        end
      end
      else if (next_r.awaddr == `ADDR_CONFIG)
      begin
        merged  = strb_merge(r.cfg, next_r.wdata, next_r.wstrb);
        new_cfg = cfg_t'(merged & `CFG_WMASK);
        if (new_cfg.seg_log > `CFG_SEG_MAX)
          new_cfg.seg_log = `CFG_SEG_MAX;
        if (!cfg_lock)
          next_r.cfg = new_cfg;
      end
      else if (next_r.awaddr == `ADDR_DELAY)
      begin
        merged = strb_merge({16'h0, r.delay}, next_r.wdata, next_r.wstrb);
        if (!cfg_lock)
          next_r.delay = merged[15:0];
      end
      else if (next_r.awaddr == `ADDR_LEADOUT)
      begin
        merged = strb_merge({16'h0, r.leadout}, next_r.wdata, next_r.wstrb);
        if (!cfg_lock)
          next_r.leadout = merged[15:0];
      end
      else if (next_r.awaddr == `ADDR_CIRCLEN)
      begin
        merged = strb_merge({16'h0, r.circlen}, next_r.wdata, next_r.wstrb);
        if (!cfg_lock)
          next_r.circlen = merged[15:0];
      end
      else if (next_r.awaddr != `ADDR_STATUS)
        next_r.rsp.bresp = `RESP_SLVERR;
    end
    next_r.rsp.awready = !next_r.aw_got && !next_r.rsp.bvalid;
    next_r.rsp.wready  = !next_r.w_got && !next_r.rsp.bvalid;

    // Read channel
    if (r.rsp.rvalid && axi_req.rready)
      next_r.rsp.rvalid = 1'b0;
    if (r.rsp.arready && axi_req.arvalid)
    begin
      next_r.rsp.rvalid = 1'b1;
      next_r.rsp.rresp  = `RESP_OKAY;
      if (axi_req.araddr == `ADDR_CTRL)
        next_r.rsp.rdata = '0;
      else if (axi_req.araddr == `ADDR_CONFIG)
        next_r.rsp.rdata = r.cfg;
      else if (axi_req.araddr == `ADDR_DELAY)
        next_r.rsp.rdata = {16'h0, r.delay};
      else if (axi_req.araddr == `ADDR_LEADOUT)
        next_r.rsp.rdata = {16'h0, r.leadout};
      else if (axi_req.araddr == `ADDR_CIRCLEN)
        next_r.rsp.rdata = {16'h0, r.circlen};
      else if (axi_req.araddr == `ADDR_STATUS)
        next_r.rsp.rdata = {r.last_sample, r.pend, r.x_busy, r.lo_run,
                            r.seg, 1'b0, r.dly_run, r.wrapped, 1'b0,
                            r.st};
      else
      begin
        next_r.rsp.rdata = '0;
        next_r.rsp.rresp = `RESP_SLVERR;
      end
    end
    next_r.rsp.arready = !next_r.rsp.rvalid;

    // Command decoding; stop outranks pause, pause outranks run except in standby and hold
    case (r.st)
      st_idle:
      begin
        if (stop_c)
          next_r.st = st_idle;
        else if (pause_c)
          next_r.st = st_standby;
        else if (run_c && !r.x_busy && !(|r.pend))
          start_c = 1'b1;
      end
      st_standby:
      begin
        if (stop_c)
          next_r.st = st_idle;
        else if (run_c && !r.x_busy && !(|r.pend))
          start_c = 1'b1;
      end
      st_record:
      begin
        if (stop_c)
        begin
          next_r.st = st_idle;
          end_sw = sweep_on && (r.wrapped || (r.off != '0));
        end
        else if (pause_c)
          next_r.st = st_hold;
      end
      st_hold:
      begin
        if (stop_c)
        begin
          next_r.st = st_idle;
          end_sw = sweep_on && (r.wrapped || (r.off != '0));
        end
        else if (run_c)
          next_r.st = st_record;
      end
      default:
        next_r.st = st_idle;
    endcase

    if (start_c)
    begin
      next_r.st        = st_record;
      next_r.seg       = '0;
      next_r.off       = '0;
      next_r.wrapped   = 1'b0;
      next_r.dly_run   = 1'b0;
      next_r.lo_run    = 1'b0;
      next_r.dec_cnt   = '0;
      next_r.cont_pos  = '0;
      next_r.trig_pend = 1'b0;
    end

    // Conversion runs in every state; only storage is gated
    if (tick)
    begin
      next_r.last_sample = adc_s;
      next_r.trig_pend   = 1'b0;
    end

    if (tick && r.st == st_record && !stop_c && !pause_c)
    begin
      if (sweep_on)
      begin
        if (r.trig_pend && !r.dly_run)
        begin
          if (r.delay == '0)
            end_sw = 1'b1;
          else
          begin
            next_r.dly_run = 1'b1;
            next_r.dly_cnt = r.delay;
          end
        end
        if (!end_sw)
        begin
          next_r.mem[base + r.off] = adc_s;
          if (7'(r.off) + 7'h1 == len)
          begin
            next_r.off     = '0;
            next_r.wrapped = 1'b1;
          end
          else
            next_r.off = r.off + 6'h1;
          // Large delays let the ring overwrite early post-trigger data
          if (next_r.dly_run)
          begin
            next_r.dly_cnt = next_r.dly_cnt - 16'h1;
            if (next_r.dly_cnt == '0)
              end_sw = 1'b1;
          end
        end
      end
      if (cont_on)
      begin
        emit = 1'b1;
        if (r.cfg.mode == sm_dual)
        begin
          emit = (r.dec_cnt == '0);
          next_r.dec_cnt = emit ? r.cfg.decim : r.dec_cnt - 8'h1;
        end
        else if (r.cfg.cmode == cm_stoptrig && r.trig_pend)
        begin
          emit      = 1'b0;
          next_r.st = st_idle;
        end
        else if (r.cfg.cmode == cm_circ && r.trig_pend && !r.lo_run)
        begin
          if (r.leadout == '0)
          begin
            emit      = 1'b0;
            next_r.st = st_idle;
          end
          else
          begin
            next_r.lo_run = 1'b1;
            next_r.lo_cnt = r.leadout;
          end
        end
        if (emit)
        begin
          next_r.cont.valid = 1'b1;
          next_r.cont.data  = adc_s;
          next_r.cont.index = r.cont_pos;
          if (r.cfg.cmode == cm_circ && r.cfg.mode == sm_cont &&
              r.cont_pos + 16'h1 >= r.circlen)
            next_r.cont_pos = '0;
          else
            next_r.cont_pos = r.cont_pos + 16'h1;
          if (next_r.lo_run)
          begin
            next_r.lo_cnt = next_r.lo_cnt - 16'h1;
            if (next_r.lo_cnt == '0)
              next_r.st = st_idle;
          end
        end
      end
    end

    // Readout engine, oldest sample of a segment first
    for (int i = 3; i >= 0; i--)
      if (r.pend[i])
        sel = 2'(i);
    if (r.xfer.valid && xfer_ready)
      next_r.xfer.valid = 1'b0;
    if (r.x_busy)
    begin
      if (!r.xfer.valid || xfer_ready)
      begin
        if (r.x_left != '0)
        begin
          next_r.xfer.valid = 1'b1;
          next_r.xfer.seg   = r.x_seg;
          next_r.xfer.data  = r.mem[xbase + r.x_off];
          next_r.x_left     = r.x_left - 7'h1;
          if (7'(r.x_off) + 7'h1 == len)
            next_r.x_off = '0;
          else
            next_r.x_off = r.x_off + 6'h1;
        end
        else
          next_r.x_busy = 1'b0;
      end
    end
    else if (|r.pend)
    begin
      next_r.x_busy    = 1'b1;
      next_r.x_seg     = sel;
      next_r.x_off     = r.m_start[sel];
      next_r.x_left    = r.m_count[sel];
      next_r.pend[sel] = 1'b0;
    end

    // Closing a sweep hands the segment over and moves to the next, or ends recording after the last
    if (end_sw)
    begin
      next_r.pend[r.seg]    = 1'b1;
      next_r.m_start[r.seg] = next_r.wrapped ? next_r.off : '0;
      next_r.m_count[r.seg] = next_r.wrapped ? len : 7'(next_r.off);
      next_r.off     = '0;
      next_r.wrapped = 1'b0;
      next_r.dly_run = 1'b0;
      if (3'(r.seg) + 3'h1 == nseg)
        next_r.st = st_idle;
      else
        next_r.seg = r.seg + 2'h1;
    end

    // A trigger landing with the consuming tick is kept
    next_r.trig_prev = trig_any;
    if ((trig_any && !r.trig_prev) || trig_c)
      next_r.trig_pend = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      r    <= '0;
      r.st <= st_idle;
    end
    else
      r <= next_r;
  end

  assign axi_rsp = r.rsp;
  assign xfer    = r.xfer;
  assign cont    = r.cont;
endmodule
`default_nettype wire

// File: sweep_ring_buffer_recorder_assertions.sv
// Port-level timing checks of the recorder
`timescale 1ns/1ps
`default_nettype none
`include "recorder_map.svh"
module recorder_checker (
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire recorder_pkg::axil_req_t axi_req,
  input wire recorder_pkg::axil_rsp_t axi_rsp,
  input wire logic [`SAMPLE_W-1:0]    adc_data,
  input wire logic [`TRIG_W-1:0]      chan_trig,
  input wire logic                    xfer_ready,
  input wire recorder_pkg::xfer_t     xfer,
  input wire recorder_pkg::cont_t     cont
);
  import recorder_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [7:0]  gap;
  logic [15:0] last_idx;
  logic        seen;
  // Spacing counter saturates so long idle spells never wrap
  always_ff @(posedge mclk)
  begin
    if (!rstn || cont.valid)
      gap <= 8'h00;
    else if (gap != 8'hff)
      gap <= gap + 8'h01;
    if (!rstn)
      seen <= 1'b0;
    else if (cont.valid)
      seen <= 1'b1;
    if (cont.valid)
      last_idx <= cont.index;
  end
  sequence wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  a_write_answer: assert property (wr_taken |=> axi_rsp.bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid) else $error("write response dropped");
  a_read_answer: assert property (rd_taken |=> axi_rsp.rvalid)
    else $error("read response missing");
  a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data moved");
  a_unmapped_err: assert property (rd_taken ##0 axi_req.araddr > 32'h14 |=>
    axi_rsp.rresp == `RESP_SLVERR) else $error("unmapped read not refused");
  a_xfer_stall: assert property (xfer.valid && !xfer_ready |=> xfer.valid
    && $stable(xfer.data) && $stable(xfer.seg)) else $error("xfer word moved");
  a_cont_pulse: assert property (cont.valid |=> (!cont.valid) [*8])
    else $error("stream pulse too long");
  a_cont_spacing: assert property (cont.valid && seen |-> gap >= 8'd124)
    else $error("stream pulses too close");
  a_cont_index: assert property (cont.valid && seen |->
    cont.index == last_idx + 16'h1 || cont.index == 16'h0)
    else $error("stream index skipped");
endmodule
bind sweep_ring_buffer_recorder recorder_checker chk (.mclk(mclk),
  .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp), .adc_data(adc_data),
  .chan_trig(chan_trig), .xfer_ready(xfer_ready), .xfer(xfer), .cont(cont));
`default_nettype wire

// File: recorder_partner.sv
// Converter source and transfer sink facing the recorder
`timescale 1ns/1ps
`default_nettype none
`include "recorder_map.svh"
module recorder_partner (
  input  wire logic                 mclk,
  output logic [`SAMPLE_W-1:0]      adc_data,
  output logic                      xfer_ready
);
  // Ramp: each sample names the cycle it was converted in
  logic [15:0] ramp = 16'h0000;
  logic [1:0]  phase = 2'h0;
  always_ff @(posedge mclk)
  begin
    ramp <= ramp + 16'h0001;
    phase <= phase + 2'h1;
  end
  assign adc_data = ramp;
  // Sink stalls one cycle in four
  assign xfer_ready = phase != 2'h0;
endmodule
`default_nettype wire

// File: tb_sweep_ring_buffer_recorder.sv
// Self-checking bench of the recorder
`timescale 1ns/1ps
`default_nettype none
`include "recorder_map.svh"
module tb_sweep_ring_buffer_recorder;
  import recorder_pkg::*;
  logic                 mclk;
  logic                 rstn;
  axil_req_t            axi_req;
  axil_rsp_t            axi_rsp;
  logic [15:0]          adc_data;
  logic [3:0]           chan_trig;
  logic                 xfer_ready;
  xfer_t                xfer;
  cont_t                cont;
  int                   miscompares = 0;
  int                   checked = 0;
  int                   cyc = 0;
  int                   npulse = 0;
  logic [15:0]          words[$];
  sweep_ring_buffer_recorder dut (.mclk(mclk), .rstn(rstn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .adc_data(adc_data),
    .chan_trig(chan_trig), .xfer_ready(xfer_ready), .xfer(xfer),
    .cont(cont));
  recorder_partner far (.mclk(mclk), .adc_data(adc_data),
    .xfer_ready(xfer_ready));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (xfer.valid && xfer_ready)
      words.push_back(xfer.data);
    if (cont.valid)
      npulse++;
    if (cyc == 70000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           output logic [1:0] rs);
    @(posedge mclk);
    axi_req <= {1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0};
    do
    begin
      @(posedge mclk);
      if (axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
    end
    while (!axi_rsp.bvalid);
    rs = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
    @(posedge mclk);
    axi_req <= {1'b0, 32'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    do
    begin
      @(posedge mclk);
      if (axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
    end
    while (!axi_rsp.rvalid);
    d = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] rs;
    axi_write(a, d, rs);
  endtask
  task automatic state_is(input logic [3:0] exp);
    logic [31:0] rd;
    logic [1:0]  rs;
    repeat (4) @(posedge mclk);
    axi_read(`ADDR_STATUS, rd, rs);
    check({28'h0, rd[3:0]}, {28'h0, exp});
  endtask
  task automatic wait_pulses(input int n);
    int k;
    k = npulse;
    wait (npulse >= k + n);
    repeat (60) @(posedge mclk);
  endtask
  task automatic reg_case;
    logic [31:0] rd;
    logic [1:0]  rs;
    axi_read(`ADDR_CONFIG, rd, rs);
    check(rd, 32'h0);
    axi_read(`ADDR_STATUS, rd, rs);
    check({16'h0, rd[15:0]}, 32'h1);
    wr(`ADDR_DELAY, 32'h1234);
    axi_read(`ADDR_DELAY, rd, rs);
    check(rd, 32'h1234);
    axi_write(32'h40, 32'h1, rs);
    check({30'h0, rs}, {30'h0, `RESP_SLVERR});
    axi_read(32'h40, rd, rs);
    check({rs, rd[29:0]}, {`RESP_SLVERR, 30'h0});
    $display("reg_case done");
  endtask
  task automatic cmd_case;
    logic [31:0] rd;
    logic [1:0]  rs;
    // Two segments, so a closed sweep moves on to the second one
    wr(`ADDR_CONFIG, 32'h10);
    wr(`ADDR_CTRL, 32'h4);
    state_is(4'h2);
    wr(`ADDR_CTRL, 32'h2);
    state_is(4'h1);
    words.delete();
    wr(`ADDR_CTRL, 32'h1);
    state_is(4'h4);
    repeat (625) @(posedge mclk);
    wr(`ADDR_CTRL, 32'h4);
    state_is(4'h8);
    repeat (375) @(posedge mclk);
    check(words.size(), 0);
    wr(`ADDR_CTRL, 32'h1);
    state_is(4'h4);
    repeat (625) @(posedge mclk);
    wr(`ADDR_CTRL, 32'h2);
    repeat (200) @(posedge mclk);
    check(words.size() != 0, 1);
    state_is(4'h1);
    axi_read(`ADDR_STATUS, rd, rs);
    check({30'h0, rd[9:8]}, 32'h1);
    $display("cmd_case done");
  endtask
  // Trigger lands mid-way between ticks so pre and post split cleanly
  task automatic sweep_case(input int d, input int ch);
    logic [15:0] t;
    int          post;
    post = 0;
    wr(`ADDR_CONFIG, 32'h2);
    wr(`ADDR_DELAY, d);
    words.delete();
    wr(`ADDR_CTRL, 32'h1);
    wait_pulses(66);
    t = adc_data;
    chan_trig[ch] <= 1'b1;
    repeat (250) @(posedge mclk);
    chan_trig <= 4'h0;
    repeat (10) @(posedge mclk);
    chan_trig[(ch + 1) % 4] <= 1'b1;
    repeat (10) @(posedge mclk);
    chan_trig <= 4'h0;
    for (int i = 0; i < 12000 && words.size() < 64; i++) @(posedge mclk);
    check(words.size(), 64);
    foreach (words[i])
    begin
      if ($signed(16'(words[i] - t)) > 0)
        post++;
      if (i > 0)
        check(32'(16'(words[i] - words[i-1])), 32'd125);
    end
    check(post, d < 64 ? d : 64);
    repeat (20) @(posedge mclk);
    state_is(4'h1);
    $display("sweep_case done");
  endtask
  task automatic cont_case(input int cm, input int ch, input int exp);
    int k;
    wr(`ADDR_CIRCLEN, 32'h8);
    wr(`ADDR_LEADOUT, 32'h5);
    wr(`ADDR_CONFIG, (cm << 2) | 1);
    wr(`ADDR_CTRL, 32'h1);
    wait_pulses(3);
    chan_trig[ch] <= 1'b1;
    k = npulse;
    repeat (1500) @(posedge mclk);
    chan_trig <= 4'h0;
    check(npulse - k, exp);
    wr(`ADDR_CTRL, 32'h2);
    state_is(4'h1);
    $display("cont_case done");
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    rstn = 1'b0;
    axi_req = '0;
    chan_trig = 4'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    reg_case;
    cmd_case;
    sweep_case(0, 0);
    sweep_case(10, 1);
    sweep_case(70, 2);
    cont_case(0, 3, 12);
    cont_case(1, 0, 5);
    cont_case(2, 1, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
